// ==== core/tdc_acquisition_control.v ====
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`include "tdc_acq_consts.vh"
// Behaviour
// - eight channels, each a 12-bit time.
// - one shared converter, channels taken in turn.
// - one full-scale range for all channels.
// - common-start: common pulse starts, channel stops.
// - common-stop: channel starts, common pulse stops.
// - event counter counts common pulses when idle and the buffer is not blocked, in common-start only with a channel enabled.
// - one low, one high threshold, all channels.
// - disabled channels never converted or stored.
// - store only enabled, in-threshold channel values.
// - output buffer is 512 by 16 FIFO.
// - halt on half full or full, selectable.
// - register-release interrupt, half full or nonempty.
// - indicator lights on every bus acknowledge.
// - busy is open-collector for wired-OR.
// - answer only address modifiers 3D, 0D, 09.
// - base address from six rotary switches.
// - all transfers are 16-bit single words.
// - busy during sequence and while buffer blocked.
// - header with count, then channel words.
// - common-start waits full-scale time before sampling.
// - control bit 15 selects start or stop.
module tdc_acquisition_control (
	input wire clock,
	input wire sys_rst,
	input wire [31:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [5:0] am_code,
	input wire [23:0] base_switch,
	input wire common_timing_input,
	input wire [7:0] chan_pulse,
	input wire busy_in,
	output wire busy_out,
	output wire busy_oe_n,
	output reg irq,
	output reg led_dtack,
	output wire led_common_start,
	output wire led_common_stop
);

reg [33:0] pin_s1_reg;
reg [33:0] pin_s2_reg;
reg [8:0] edge_reg;
reg [15:0] ctl_reg;
reg [7:0] range_reg;
reg [11:0] thrh_reg;
reg [11:0] thrl_reg;
reg [1:0] intr_reg;
reg [11:0] evcnt_reg;
reg [2:0] state_reg;
reg [7:0] run_reg;
reg [11:0] sect_reg [0:7];
reg [4:0] tmo_reg;
reg [4:0] conv_reg;
reg [2:0] idx_reg;
reg [7:0] mask_reg;
reg [3:0] cnt_reg;
reg [11:0] adc_reg;
reg [8:0] wr_ptr_reg;
reg [8:0] rd_ptr_reg;
reg [9:0] level_reg;
reg [31:0] rdata_reg;
reg outbuf_rd_reg;
reg pop_ok_reg;
reg cond_d_reg;
reg [15:0] wr_word;
reg [7:0] in_mask;
wire [15:0] mem_rdata;
integer i;
integer j;
localparam integer fs_min_cyc = `FS_MIN_CYC;
localparam integer fs_max_cyc = `FS_MAX_CYC;

// In-window test shared by every channel.
function in_range;
	input [11:0] v;
	input [11:0] lo;
	input [11:0] hi;
	begin
		in_range = (v >= lo) && (v <= hi);
	end
endfunction

// Number of set bits in a channel mask.
function [3:0] popcount8;
	input [7:0] m;
	integer k;
	begin
		popcount8 = 4'h0;
		for (k = 0; k < 8; k = k + 1) begin
			popcount8 = popcount8 + {3'h0, m[k]};
		end
	end
endfunction

// Full-scale wait in cycles; the range code steps it linearly.
function [4:0] fs_cycles;
	input [7:0] r;
	reg [5:0] t;
	begin
		t = fs_min_cyc[5:0] + {2'h0, r[7:4]};
		if (t > fs_max_cyc[5:0]) begin
			t = fs_max_cyc[5:0];
		end
		fs_cycles = t[4:0];
	end
endfunction

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers; only the second stage and later are looked at.
always @(posedge clock or posedge sys_rst) begin
	if (sys_rst) begin
		pin_s1_reg <= 34'h0;
		pin_s2_reg <= 34'h0;
		edge_reg <= 9'h0;
	end else begin
		pin_s1_reg <= {busy_in, base_switch, chan_pulse, common_timing_input};
		pin_s2_reg <= pin_s1_reg;
		edge_reg <= pin_s2_reg[8:0];
	end
end

wire trig_edge = pin_s2_reg[0] & ~edge_reg[0];
wire [7:0] chan_edge = pin_s2_reg[8:1] & ~edge_reg[8:1];
wire [23:0] sw = pin_s2_reg[32:9];
wire mode_stop = ctl_reg[`CTL_MODE_BIT];
wire [7:0] chan_en = ctl_reg[7:0];

////////////////////////////////////////////////////////////////////////////
// Bus decode: address modifier, switch base and register index.
wire am_a24 = (am_code == `AM_STD_SUP);
wire am_a32 = (am_code == `AM_EXT_SUP) || (am_code == `AM_EXT_USR);
wire base_hit = (am_a24 && paddr[31:24] == 8'h00 &&
	paddr[23:8] == sw[15:0]) ||
	(am_a32 && paddr[31:8] == sw);
wire [5:0] idx = paddr[7:2];
reg idx_ok;

// Only the listed indices exist; all else is refused with an error.
always @* begin
	if (idx == `IDX_STATUS || idx == `IDX_EVCNT || idx == `IDX_OUTBUF) begin
		idx_ok = 1'b1;
	end else if (idx == `IDX_SOFTRST || idx == `IDX_RANGE) begin
		idx_ok = 1'b1;
	end else if (idx == `IDX_THRH || idx == `IDX_THRL) begin
		idx_ok = 1'b1;
	end else if (idx == `IDX_CONTROL || idx == `IDX_INTR) begin
		idx_ok = 1'b1;
	end else begin
		idx_ok = 1'b0;
	end
end

wire hit = base_hit & idx_ok;
wire access = psel & penable;
wire setup = psel & ~penable;
wire wr_acc = access & pwrite & hit;
wire soft_clr = wr_acc && idx == `IDX_SOFTRST;
assign pready = 1'b1;
assign pslverr = access & ~hit;

////////////////////////////////////////////////////////////////////////////
// Output buffer flags and the busy term.
wire fifo_empty = (level_reg == 10'h000);
wire fifo_half = (level_reg >= `FIFO_HALF);
wire fifo_full = (level_reg == `FIFO_DEPTH);
wire fifo_block = ctl_reg[`CTL_HALT_HALF_BIT] ? fifo_half : fifo_full;
wire busy = (state_reg != `ST_IDLE) | fifo_block;
assign busy_out = 1'b1;
assign busy_oe_n = ~busy;
assign led_common_start = ~mode_stop;
assign led_common_stop = mode_stop;

////////////////////////////////////////////////////////////////////////////
// Software registers; data live in the low 16 bits only.
always @(posedge clock or posedge sys_rst) begin
	if (sys_rst) begin
		ctl_reg <= `CTL_RESET;
		range_reg <= `RANGE_RESET;
		thrh_reg <= `THRH_RESET;
		thrl_reg <= `THRL_RESET;
		intr_reg <= 2'h0;
	end else if (wr_acc) begin
		if (idx == `IDX_CONTROL) begin
			ctl_reg <= pwdata[15:0];
		end else if (idx == `IDX_RANGE) begin
			range_reg <= pwdata[7:0];
		end else if (idx == `IDX_THRH) begin
			thrh_reg <= pwdata[11:0];
		end else if (idx == `IDX_THRL) begin
			thrl_reg <= pwdata[11:0];
		end else if (idx == `IDX_INTR) begin
			intr_reg <= pwdata[1:0];
		end
	end
end

// Read data is captured in the setup cycle; buffer words come from the RAM.
always @(posedge clock or posedge sys_rst) begin
	if (sys_rst) begin
		rdata_reg <= 32'h0;
		outbuf_rd_reg <= 1'b0;
		pop_ok_reg <= 1'b0;
	end else if (setup) begin
		outbuf_rd_reg <= hit && !pwrite && idx == `IDX_OUTBUF;
		pop_ok_reg <= hit && !pwrite && idx == `IDX_OUTBUF && !fifo_empty;
		if (idx == `IDX_STATUS) begin
			rdata_reg <= {26'h0, irq, pin_s2_reg[33], fifo_full, fifo_half,
				fifo_empty, busy};
		end else if (idx == `IDX_EVCNT) begin
			rdata_reg <= {20'h0, evcnt_reg};
		end else if (idx == `IDX_RANGE) begin
			rdata_reg <= {24'h0, range_reg};
		end else if (idx == `IDX_THRH) begin
			rdata_reg <= {20'h0, thrh_reg};
		end else if (idx == `IDX_THRL) begin
			rdata_reg <= {20'h0, thrl_reg};
		end else if (idx == `IDX_CONTROL) begin
			rdata_reg <= {16'h0, ctl_reg};
		end else if (idx == `IDX_INTR) begin
			rdata_reg <= {30'h0, intr_reg};
		end else begin
			rdata_reg <= 32'h0;
		end
	end
end

// An empty buffer reads as zero and nothing is popped.
assign prdata = outbuf_rd_reg ?
	{16'h0, pop_ok_reg ? mem_rdata : 16'h0} : rdata_reg;

// The indicator pulses on each acknowledged cycle of this module.
always @(posedge clock or posedge sys_rst) begin
	if (sys_rst) begin
		led_dtack <= 1'b0;
	end else begin
		led_dtack <= access & hit;
	end
end

////////////////////////////////////////////////////////////////////////////
// Acquisition sequencer with the per-channel time counters.
always @* begin
	for (j = 0; j < 8; j = j + 1) begin
		in_mask[j] = chan_en[j] & in_range(sect_reg[j], thrl_reg, thrh_reg);
	end
end

wire do_write = (state_reg == `ST_HEAD || state_reg == `ST_STORE) &&
	!fifo_full;
wire [4:0] fs_wait = fs_cycles(range_reg);

always @* begin
	if (state_reg == `ST_HEAD) begin
		wr_word = {1'b1, cnt_reg[2:0] - 3'h1, evcnt_reg};
	end else begin
		wr_word = {1'b0, idx_reg, adc_reg};
	end
end

always @(posedge clock or posedge sys_rst) begin
	if (sys_rst) begin
		state_reg <= `ST_IDLE;
		evcnt_reg <= 12'h000;
		run_reg <= 8'h00;
		tmo_reg <= 5'h00;
		conv_reg <= 5'h00;
		idx_reg <= 3'h0;
		mask_reg <= 8'h00;
		cnt_reg <= 4'h0;
		adc_reg <= 12'h000;
		for (i = 0; i < 8; i = i + 1) begin
			sect_reg[i] <= 12'h000;
		end
	end else if (soft_clr) begin
		state_reg <= `ST_IDLE;
		evcnt_reg <= 12'h000;
		run_reg <= 8'h00;
		for (i = 0; i < 8; i = i + 1) begin
			sect_reg[i] <= 12'h000;
		end
	end else begin
		// Running sections saturate rather than wrap past full scale.
		for (i = 0; i < 8; i = i + 1) begin
			if (run_reg[i] && sect_reg[i] != 12'hfff) begin
				sect_reg[i] <= sect_reg[i] + 12'h001;
			end
		end
		case (state_reg)
		`ST_IDLE: begin
			if (!fifo_block && !mode_stop) begin
				if (trig_edge && chan_en != 8'h00) begin
					evcnt_reg <= evcnt_reg + 12'h001;
					run_reg <= chan_en;
					tmo_reg <= 5'h00;
					state_reg <= `ST_TIMING;
					for (i = 0; i < 8; i = i + 1) begin
						sect_reg[i] <= 12'h000;
					end
				end
			end else if (!fifo_block) begin
				run_reg <= run_reg | (chan_edge & chan_en);
				for (i = 0; i < 8; i = i + 1) begin
					if (chan_edge[i] && chan_en[i] && !run_reg[i]) begin
						sect_reg[i] <= 12'h000;
					end
				end
				if (trig_edge) begin
					evcnt_reg <= evcnt_reg + 12'h001;
					run_reg <= 8'h00;
					state_reg <= `ST_SCAN;
				end
			end
		end
		`ST_TIMING: begin
			run_reg <= run_reg & ~chan_edge;
			tmo_reg <= tmo_reg + 5'h01;
			if (tmo_reg == fs_wait - 5'h01) begin
				// Sections never stopped read as overflow.
				for (i = 0; i < 8; i = i + 1) begin
					if (run_reg[i] && !chan_edge[i]) begin
						sect_reg[i] <= 12'hfff;
					end
				end
				run_reg <= 8'h00;
				state_reg <= `ST_SCAN;
			end
		end
		`ST_SCAN: begin
			mask_reg <= in_mask;
			cnt_reg <= popcount8(in_mask);
			idx_reg <= 3'h0;
			state_reg <= (in_mask == 8'h00) ? `ST_DONE : `ST_HEAD;
		end
		`ST_HEAD: begin
			if (do_write) begin
				state_reg <= `ST_PICK;
			end
		end
		`ST_PICK: begin
			conv_reg <= 5'h00;
			if (mask_reg[idx_reg]) begin
				state_reg <= `ST_CONV;
			end else if (idx_reg == 3'h7) begin
				state_reg <= `ST_DONE;
			end else begin
				idx_reg <= idx_reg + 3'h1;
			end
		end
		`ST_CONV: begin
			// One shared converter; the mux picks the current section.
			conv_reg <= conv_reg + 5'h01;
			if (conv_reg == (`CONV_CYC) - 1) begin
				adc_reg <= sect_reg[idx_reg];
				state_reg <= `ST_STORE;
			end
		end
		`ST_STORE: begin
			if (do_write) begin
				if (idx_reg == 3'h7) begin
					state_reg <= `ST_DONE;
				end else begin
					idx_reg <= idx_reg + 3'h1;
					state_reg <= `ST_PICK;
				end
			end
		end
		default: begin
			run_reg <= 8'h00;
			for (i = 0; i < 8; i = i + 1) begin
				sect_reg[i] <= 12'h000;
			end
			state_reg <= `ST_IDLE;
		end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////
// Buffer pointers; a pop needs a word that was present at setup time.
wire pop = access & pop_ok_reg;
wire push = do_write & ~soft_clr;

always @(posedge clock or posedge sys_rst) begin
	if (sys_rst) begin
		wr_ptr_reg <= 9'h000;
		rd_ptr_reg <= 9'h000;
		level_reg <= 10'h000;
	end else if (soft_clr) begin
		wr_ptr_reg <= 9'h000;
		rd_ptr_reg <= 9'h000;
		level_reg <= 10'h000;
	end else begin
		if (push) begin
			wr_ptr_reg <= wr_ptr_reg + 9'h001;
		end
		if (pop) begin
			rd_ptr_reg <= rd_ptr_reg + 9'h001;
		end
		if (push && !pop) begin
			level_reg <= level_reg + 10'h001;
		end else if (pop && !push) begin
			level_reg <= level_reg - 10'h001;
		end
	end
end

fifo_store_ram u_store (
	.clock(clock),
	.wr_en(push),
	.wr_addr(wr_ptr_reg),
	.wr_data(wr_word),
	.rd_en(setup),
	.rd_addr(rd_ptr_reg),
	.rd_data(mem_rdata)
);

////////////////////////////////////////////////////////////////////////////
// Interrupt stays up until software writes the interrupt register; a new
// rising condition in that same cycle wins over the release.
wire irq_cond = intr_reg[`INTR_SRC_HALF_BIT] ? fifo_half : ~fifo_empty;
wire irq_rise = irq_cond & ~cond_d_reg & intr_reg[`INTR_ENABLE_BIT];

always @(posedge clock or posedge sys_rst) begin
	if (sys_rst) begin
		cond_d_reg <= 1'b0;
		irq <= 1'b0;
	end else begin
		cond_d_reg <= irq_cond;
		if (irq_rise) begin
			irq <= 1'b1;
		end else if (wr_acc && idx == `IDX_INTR) begin
			irq <= 1'b0;
		end
	end
end

endmodule

// ==== core/tdc_acq_consts.vh ====
`ifndef TDC_ACQ_CONSTS_VH
`define TDC_ACQ_CONSTS_VH

// Register indices; the byte address of each register is four times these.
`define IDX_STATUS 6'h02
`define IDX_EVCNT 6'h04
`define IDX_OUTBUF 6'h10
`define IDX_SOFTRST 6'h12
`define IDX_RANGE 6'h14
`define IDX_THRH 6'h16
`define IDX_THRL 6'h18
`define IDX_CONTROL 6'h1a
`define IDX_INTR 6'h1c

// Control register fields.
`define CTL_MODE_BIT 15
`define CTL_HALT_HALF_BIT 8
`define CTL_ENABLE_LSB 0
`define CTL_RESET 16'h00ff

// Interrupt register fields.
`define INTR_ENABLE_BIT 0
`define INTR_SRC_HALF_BIT 1

// Reset values of the range and threshold registers.
`define RANGE_RESET 8'h00
`define THRH_RESET 12'hfff
`define THRL_RESET 12'h000

// Address modifier codes that are answered.
`define AM_STD_SUP 6'h3d
`define AM_EXT_SUP 6'h0d
`define AM_EXT_USR 6'h09

// Output buffer geometry.
`define FIFO_AW 9
`define FIFO_DW 16
`define FIFO_DEPTH 10'h200
`define FIFO_HALF 10'h100

// Timing figures in ns, and derived cycle counts at the clock rate.
`define CLK_NS 40
`define FS_MIN_NS 90
`define FS_MAX_NS 770
`define CONV_NS 1000
`define FS_MIN_CYC ((`FS_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define FS_MAX_CYC (`FS_MAX_NS / `CLK_NS)
`define CONV_CYC ((`CONV_NS + `CLK_NS - 1) / `CLK_NS)

// Sequencer states.
`define ST_IDLE 3'h0
`define ST_TIMING 3'h1
`define ST_SCAN 3'h2
`define ST_HEAD 3'h3
`define ST_PICK 3'h4
`define ST_CONV 3'h5
`define ST_STORE 3'h6
`define ST_DONE 3'h7

`endif

// ==== core/fifo_store_ram.v ====
`timescale 1ns/10ps
module fifo_store_ram (
	input wire clock,
	input wire wr_en,
	input wire [8:0] wr_addr,
	input wire [15:0] wr_data,
	input wire rd_en,
	input wire [8:0] rd_addr,
	output reg [15:0] rd_data
);

reg [15:0] mem [0:511];

// Plain storage with no reset, so it maps onto a block memory.
always @(posedge clock) begin
	if (wr_en) begin
		mem[wr_addr] <= wr_data;
	end
	if (rd_en) begin
		rd_data <= mem[rd_addr];
	end
end

endmodule

// ==== tb/front_end_model.sv ====
`timescale 1ns/10ps
module front_end_model (
	input wire clock,
	input wire busy_out,
	input wire busy_oe_n,
	output logic common_timing_input,
	output logic [7:0] chan_pulse,
	output wire busy_in
);
	// The shared busy wire has a pull-down, so a released line reads low.
	assign busy_in = !busy_oe_n ? busy_out : 1'b0;

	initial begin
		common_timing_input = 1'b0;
		chan_pulse = 8'h00;
	end

	// Pulses last four cycles so that the input synchroniser sees them.
	task automatic pulse(input logic trig, input logic [7:0] ch);
		@(posedge clock);
		common_timing_input <= trig;
		chan_pulse <= ch;
		repeat (4) @(posedge clock);
		common_timing_input <= 1'b0;
		chan_pulse <= 8'h00;
	endtask
endmodule

// ==== tb/tdc_acq_props.sv ====
`timescale 1ns/10ps
module tdc_acq_props (
	input wire clock,
	input wire sys_rst,
	input wire [31:0] paddr,
	input wire psel,
	input wire penable,
	input wire [5:0] am_code,
	input wire [23:0] base_switch,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire busy_out,
	input wire busy_oe_n,
	input wire led_dtack,
	input wire led_common_start,
	input wire led_common_stop
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	// Access phase and accepted address modifier, shared by the checks.
	wire acc = psel && penable;
	wire am_ok = am_code == 6'h3d || am_code == 6'h0d || am_code == 6'h09;
	wire a32_miss = am_code != 6'h3d && paddr[31:8] != base_switch;

	chk_dtack_hit: assert property (acc && !pslverr |=> led_dtack)
		else $error("Acknowledge light missed an access.");
	chk_dtack_cause: assert property (led_dtack |-> $past(acc && !pslverr))
		else $error("Acknowledge light without an access.");
	chk_am_refuse: assert property (acc && !am_ok |-> pslverr)
		else $error("Foreign modifier was answered.");
	chk_base_refuse: assert property (acc && a32_miss |-> pslverr)
		else $error("Foreign base address was answered.");
	chk_busy_drive: assert property (!busy_oe_n |-> busy_out)
		else $error("Busy line driven to the wrong level.");
	chk_word_width: assert property (prdata[31:16] == 16'h0000)
		else $error("Read data wider than one word.");
	chk_mode_leds: assert property (led_common_start == !led_common_stop)
		else $error("Mode lights disagree.");
	// A start-mode sequence cannot end before the shortest full-scale wait.
	chk_busy_span: assert property (led_common_start && $fell(busy_oe_n) |-> !busy_oe_n [*3])
		else $error("Busy released before the full-scale wait.");
endmodule

bind tdc_acquisition_control tdc_acq_props chk (
	.clock(clock),
	.sys_rst(sys_rst),
	.paddr(paddr),
	.psel(psel),
	.penable(penable),
	.am_code(am_code),
	.base_switch(base_switch),
	.prdata(prdata),
	.pslverr(pslverr),
	.busy_out(busy_out),
	.busy_oe_n(busy_oe_n),
	.led_dtack(led_dtack),
	.led_common_start(led_common_start),
	.led_common_stop(led_common_stop)
);

// ==== tb/tdc_acquisition_control_tb.sv ====
`timescale 1ns/10ps
`include "tdc_acq_consts.vh"
module tdc_acquisition_control_tb;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [31:0] paddr = 32'h0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [5:0] am_code = 6'h0d;
	logic [23:0] base = 24'h000012;
	wire [31:0] prdata;
	wire [7:0] chan_pulse;
	wire pready, pslverr, common_timing_input, busy_in, busy_out;
	wire busy_oe_n, irq, led_dtack, led_common_start, led_common_stop;
	integer num_errors = 0;
	integer cmp_count = 0;
	integer len;
	logic [15:0] q;
	logic e;

	always #20 clock = ~clock;

	// The switches are fixed, as on a board in a crate.
	tdc_acquisition_control dut (.clock(clock), .sys_rst(sys_rst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .am_code(am_code), .base_switch(24'h000012),
		.common_timing_input(common_timing_input),
		.chan_pulse(chan_pulse), .busy_in(busy_in), .busy_out(busy_out),
		.busy_oe_n(busy_oe_n), .irq(irq), .led_dtack(led_dtack),
		.led_common_start(led_common_start),
		.led_common_stop(led_common_stop));

	front_end_model fe (.clock(clock), .busy_out(busy_out),
		.busy_oe_n(busy_oe_n), .common_timing_input(common_timing_input),
		.chan_pulse(chan_pulse), .busy_in(busy_in));

	////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [15:0] x,
		input logic [15:0] g);
		cmp_count++;
		if (g !== x) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask

	// One word per transfer; the request holds until pready is sampled.
	task automatic apb(input logic w, input logic [5:0] idx,
		input logic [15:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {base, idx, 2'b00};
		pwdata <= {16'h0000, d};
		@(posedge clock);
		penable <= 1'b1;
		// No wait count is assumed; only the watchdog ends a hung cycle.
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata[15:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] idx, input logic [15:0] x,
		input string nm);
		apb(1'b0, idx, 16'h0000);
		check(nm, x, q);
	endtask

	task automatic wait_busy;
		while (busy_oe_n !== 1'b0) begin
			@(posedge clock);
		end
	endtask

	task automatic wait_idle(output integer k);
		k = 0;
		while (busy_oe_n === 1'b0) begin
			@(posedge clock);
			k++;
		end
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic reset_values;
		rd(`IDX_CONTROL, `CTL_RESET, "control");
		rd(`IDX_THRH, 16'h0fff, "thrh");
		rd(`IDX_THRL, 16'h0000, "thrl");
		rd(`IDX_RANGE, 16'h0000, "range");
		rd(`IDX_STATUS, 16'h0002, "status");
		check("start led", 16'h0001, {15'h0, led_common_start});
	endtask

	task automatic refusals;
		logic [17:0] codes;
		codes = {6'h3d, 6'h09, 6'h0d};
		am_code <= 6'h39;
		apb(1'b1, `IDX_THRH, 16'h0123);
		check("am refused", 16'h0001, {15'h0, e});
		am_code <= 6'h0d;
		rd(`IDX_THRH, 16'h0fff, "thrh kept");
		base <= 24'h000013;
		apb(1'b0, `IDX_CONTROL, 16'h0000);
		check("base refused", 16'h0001, {15'h0, e});
		base <= 24'h000012;
		apb(1'b0, 6'h3f, 16'h0000);
		check("index refused", 16'h0001, {15'h0, e});
		for (int i = 0; i < 3; i++) begin
			am_code <= codes[6 * i +: 6];
			rd(`IDX_CONTROL, `CTL_RESET, "am taken");
		end
	endtask

	// Channel 1 is stopped early, channel 0 runs to full scale.
	task automatic start_event;
		apb(1'b1, `IDX_CONTROL, 16'h0003);
		apb(1'b1, `IDX_RANGE, 16'h00f0);
		fe.pulse(1'b1, 8'h00);
		wait_busy();
		rd(`IDX_STATUS, 16'h0013, "status busy");
		fe.pulse(1'b0, 8'h02);
		wait_idle(len);
		rd(`IDX_OUTBUF, 16'h9001, "header");
		rd(`IDX_OUTBUF, 16'h0fff, "ch0 word");
		apb(1'b0, `IDX_OUTBUF, 16'h0000);
		check("ch1 word", 16'h1001, {q[15:12], 11'h0, q[11:0] < 12'h013});
		rd(`IDX_OUTBUF, 16'h0000, "drained");
		rd(`IDX_EVCNT, 16'h0001, "evcnt");
	endtask

	// Nothing in range, and a second trigger lands while busy.
	task automatic reject_event;
		apb(1'b1, `IDX_THRH, 16'h0ffe);
		fe.pulse(1'b1, 8'h00);
		wait_busy();
		fe.pulse(1'b1, 8'h00);
		wait_idle(len);
		check("busy span", 16'h0001, {15'h0, len >= 12 && len <= 20});
		rd(`IDX_STATUS, 16'h0002, "none stored");
		rd(`IDX_EVCNT, 16'h0002, "evcnt busy");
	endtask

	task automatic stop_event;
		apb(1'b1, `IDX_THRH, 16'h0fff);
		apb(1'b1, `IDX_INTR, 16'h0001);
		apb(1'b1, `IDX_CONTROL, 16'h8001);
		fe.pulse(1'b0, 8'h01);
		fe.pulse(1'b1, 8'h00);
		wait_busy();
		wait_idle(len);
		check("stop led", 16'h0001, {15'h0, led_common_stop});
		check("irq set", 16'h0001, {15'h0, irq});
		apb(1'b1, `IDX_INTR, 16'h0001);
		@(posedge clock);
		check("irq freed", 16'h0000, {15'h0, irq});
		rd(`IDX_OUTBUF, 16'h8003, "stop header");
		apb(1'b0, `IDX_OUTBUF, 16'h0000);
		check("stop word", 16'h0001, {q[15:12], 11'h0, q[11:0] < 12'h020});
		apb(1'b1, `IDX_SOFTRST, 16'h0000);
		rd(`IDX_EVCNT, 16'h0000, "evcnt cleared");
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Reset is held, then the synchronisers get a few edges to settle.
	initial begin
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clock);
		reset_values();
		refusals();
		start_event();
		reject_event();
		stop_event();
		report_and_stop();
	end

	// The whole run needs well under two thousand cycles.
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		report_and_stop();
	end
endmodule
